// ==== rtl/aasc_step_cfg.sv ====
// Channel-B sequencer step 12/13 configuration registers on classic Wishbone
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module aasc_step_cfg
   import aasc_pkg::*;
#(
   parameter int ADR_W = 10
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic [AASC_STEPS-1:0] step_active_o,
   output logic [AASC_STEPS-1:0][2:0] step_gain_factor_o,
   output logic [AASC_STEPS-1:0][3:0] step_positive_input_o,
   output logic [AASC_STEPS-1:0][5:0] step_source_class_o,
   output logic [AASC_STEPS-1:0] step_negative_auto_o,
   output logic [AASC_STEPS-1:0] step_negative_external_seven_o
);

   // Map and field sanity; the decode below leans on every one of these
   if (ADR_W < AASC_IDX_LSB + AASC_IDX_W) begin : g_adr_check
      $error("ADR_W too small for the register map");
   end

   if (AASC_STEPS != 2) begin : g_steps_check
      $error("index table is written for two steps");
   end

   if (AASC_IDX_STEP12 == AASC_IDX_STEP13) begin : g_idx_check
      $error("step registers share an index");
   end

   if (AASC_IDX_W != 8) begin : g_idx_w_check
      $error("index table entries are eight bits");
   end

   if (AASC_IDX_LSB != 2) begin : g_idx_lsb_check
      $error("registers must sit on word addresses");
   end

   if (AASC_GAIN_HI != AASC_GAIN_LO + 1) begin : g_gain_check
      $error("gain field must be two bits wide");
   end

   if (AASC_POS_HI - AASC_POS_LO != 3) begin : g_pos_check
      $error("positive field must be four bits wide");
   end

   if (AASC_NEG_BIT <= AASC_POS_HI || AASC_NEG_BIT >= AASC_GAIN_LO) begin : g_neg_check
      $error("negative select overlaps another field");
   end

   if (AASC_EN_BIT <= AASC_GAIN_HI || AASC_EN_BIT > 15) begin : g_en_check
      $error("enable bit outside the register");
   end

   if (AASC_RST_STEP12[AASC_EN_BIT] || AASC_RST_STEP13[AASC_EN_BIT]) begin : g_rst_check
      $error("steps must leave reset disabled");
   end

   if ((AASC_RST_STEP12 & ~AASC_WR_MASK) != '0) begin : g_rsvd12_check
      $error("step 12 reset value sets reserved bits");
   end

   if ((AASC_RST_STEP13 & ~AASC_WR_MASK) != '0) begin : g_rsvd13_check
      $error("step 13 reset value sets reserved bits");
   end

   if (!AASC_WR_MASK[AASC_EN_BIT]) begin : g_mask_en_check
      $error("enable bit must be writable");
   end

   if (!AASC_WR_MASK[AASC_NEG_BIT]) begin : g_mask_neg_check
      $error("negative select must be writable");
   end

   if (AASC_WR_MASK[AASC_POS_HI:AASC_POS_LO] != 4'hF) begin : g_mask_pos_check
      $error("positive field must be writable");
   end

   if (AASC_WR_MASK[AASC_GAIN_HI:AASC_GAIN_LO] != 2'h3) begin : g_mask_gain_check
      $error("gain field must be writable");
   end

   // Automatic negative selection is a plain compare against the last external code
   if (AASC_POS_TEMP != AASC_POS_EXT_LAST + 4'h1) begin : g_ext_order_check
      $error("internal codes must follow the external ones");
   end

   if (AASC_POS_SHORT <= AASC_POS_TEMP) begin : g_short_order_check
      $error("short code must follow the temperature code");
   end

   if (AASC_POS_DAC <= AASC_POS_SHORT) begin : g_dac_order_check
      $error("test source code must follow the short code");
   end

   if (AASC_POS_IO_DIV4 <= AASC_POS_DAC) begin : g_supply_order_check
      $error("supply codes must sit above the test source");
   end

   if (AASC_POS_IO_DIV4 == AASC_POS_CORE_DIV2) begin : g_supply_dup_check
      $error("supply codes must differ");
   end

   if (AASC_POS_ANA_PWR_DIV == AASC_POS_DIG_PWR_DIV) begin : g_power_dup_check
      $error("power input codes must differ");
   end

   if (AASC_GAIN_CODE_X1 == AASC_GAIN_CODE_X2) begin : g_gain_code_check
      $error("gain codes must differ");
   end

   if (AASC_GAIN_X1 == AASC_GAIN_X2 || AASC_GAIN_X2 == AASC_GAIN_X4) begin : g_gain_val_check
      $error("gain factors must differ");
   end

   // Decoded view of one step register
   typedef struct packed {
      logic active;
      logic [2:0] gain;
      logic [3:0] pos;
      logic [5:0] src;
      logic neg_auto;
      logic neg_ext;
   } aasc_decode_t;

   // Codes 10 and 11 both give x4
   function automatic logic [2:0] gain_of(input logic [1:0] code);
      logic [2:0] g;
      g = AASC_GAIN_X4;
      case (code)
         AASC_GAIN_CODE_X1: begin
            g = AASC_GAIN_X1;
         end
         AASC_GAIN_CODE_X2: begin
            g = AASC_GAIN_X2;
         end
         default: begin
            g = AASC_GAIN_X4;
         end
      endcase
      return g;
   endfunction

   // Source class of an enabled positive code
   function automatic logic [5:0] class_of(input logic [3:0] p);
      logic [5:0] c;
      c = AASC_SRC_RSVD;
      if (p <= AASC_POS_EXT_LAST) begin
         c = AASC_SRC_EXT;
      end else begin
         case (p)
            AASC_POS_TEMP: begin
               c = AASC_SRC_TEMP;
            end
            AASC_POS_SHORT: begin
               c = AASC_SRC_SHORT;
            end
            AASC_POS_DAC: begin
               c = AASC_SRC_DAC;
            end
            AASC_POS_IO_DIV4: begin
               c = AASC_SRC_SUPPLY;
            end
            AASC_POS_CORE_DIV2: begin
               c = AASC_SRC_SUPPLY;
            end
            AASC_POS_ANA_PWR_DIV: begin
               c = AASC_SRC_SUPPLY;
            end
            AASC_POS_DIG_PWR_DIV: begin
               c = AASC_SRC_SUPPLY;
            end
            default: begin
               // Unlisted code kept apart so a sequencer can flag it
               c = AASC_SRC_RSVD;
            end
         endcase
      end
      return c;
   endfunction

   // Full decode of one step register; a disabled step drives nothing
   function automatic aasc_decode_t decode_step(input logic [15:0] f);
      aasc_decode_t d;
      logic en;
      logic [3:0] p;
      logic auto_sel;
      d = '0;
      en = f[AASC_EN_BIT];
      p = f[AASC_POS_HI:AASC_POS_LO];
      // Every non-external code, the unlisted one included, picks its own negative
      auto_sel = (p > AASC_POS_EXT_LAST);
      if (en) begin
         d.active = 1'b1;
         d.gain = gain_of(f[AASC_GAIN_HI:AASC_GAIN_LO]);
         d.pos = p;
         d.src = class_of(p);
         d.neg_auto = auto_sel;
         // Negative select bit only counts for external codes
         d.neg_ext = !auto_sel && f[AASC_NEG_BIT];
      end else begin
         // Sequencer skips the step, so nothing is applied
         d = '0;
      end
      return d;
   endfunction

   // Byte-lane write with reserved bits held at zero
   function automatic logic [15:0] merge_write(
      input logic [15:0] old_val,
      input logic [15:0] wdat,
      input logic [1:0] sel
   );
      logic [15:0] n;
      n = old_val;
      if (sel[0]) begin
         n[7:0] = wdat[7:0] & AASC_WR_MASK[7:0];
      end
      if (sel[1]) begin
         n[15:8] = wdat[15:8] & AASC_WR_MASK[15:8];
      end
      return n;
   endfunction

   // Read view: upper half unused, reserved bits masked again for safety
   function automatic logic [31:0] read_word(input logic [15:0] r);
      logic [31:0] w;
      w = '0;
      w[15:0] = r & AASC_WR_MASK;
      return w;
   endfunction

   // Upper address bits must be zero, so aliases above the map never hit
   function automatic logic addr_hit(
      input logic [ADR_W-1:0] adr,
      input logic [AASC_IDX_W-1:0] idx
   );
      logic upper_ok;
      upper_ok = 1'b1;
      if (ADR_W > AASC_IDX_LSB + AASC_IDX_W) begin
         upper_ok = ((adr >> (AASC_IDX_LSB + AASC_IDX_W)) == '0);
      end
      return upper_ok && (adr[AASC_IDX_LSB +: AASC_IDX_W] == idx);
   endfunction

   typedef struct packed {
      logic [AASC_STEPS-1:0][15:0] cfg;
      logic ack;
      logic [31:0] rdat;
      logic [AASC_STEPS-1:0] active;
      logic [AASC_STEPS-1:0][2:0] gain;
      logic [AASC_STEPS-1:0][3:0] pos;
      logic [AASC_STEPS-1:0][5:0] src;
      logic [AASC_STEPS-1:0] neg_auto;
      logic [AASC_STEPS-1:0] neg_ext;
   } aasc_state_t;

   localparam logic [AASC_STEPS-1:0][7:0] IDX_TAB = {AASC_IDX_STEP13, AASC_IDX_STEP12};

   aasc_state_t state_q;
   aasc_state_t state_d;

   always_comb begin
      logic req;
      logic [AASC_STEPS-1:0] hit;
      aasc_decode_t dec;
      req = 1'b0;
      hit = '0;
      dec = '0;
      state_d = state_q;

      // One wait state; ack drops as soon as it has been seen
      req = wb_cyc_i && wb_stb_i && !state_q.ack;
      state_d.ack = req;
      // Read data is zero outside an ack, so a stale word never lingers
      state_d.rdat = '0;

      for (int i = 0; i < AASC_STEPS; i++) begin
         hit[i] = addr_hit(wb_adr_i, IDX_TAB[i]);
      end

      // Unmapped addresses still get ack with zero data
      for (int i = 0; i < AASC_STEPS; i++) begin
         if (req && hit[i]) begin
            state_d.rdat = read_word(state_q.cfg[i]);
            if (wb_we_i) begin
               state_d.cfg[i] = merge_write(state_q.cfg[i], wb_dat_i[15:0],
                                            wb_sel_i[1:0]);
            end
         end
      end

      // Decode from the new value so outputs follow the write edge
      for (int i = 0; i < AASC_STEPS; i++) begin
         dec = decode_step(state_d.cfg[i]);
         state_d.active[i] = dec.active;
         state_d.gain[i] = dec.gain;
         state_d.pos[i] = dec.pos;
         state_d.src[i] = dec.src;
         state_d.neg_auto[i] = dec.neg_auto;
         state_d.neg_ext[i] = dec.neg_ext;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= '0;
         state_q.cfg[0] <= AASC_RST_STEP12;
         state_q.cfg[1] <= AASC_RST_STEP13;
      end else begin
         state_q <= state_d;
      end
   end

   assign wb_dat_o = state_q.rdat;
   assign wb_ack_o = state_q.ack;
   assign step_active_o = state_q.active;
   assign step_gain_factor_o = state_q.gain;
   assign step_positive_input_o = state_q.pos;
   assign step_source_class_o = state_q.src;
   assign step_negative_auto_o = state_q.neg_auto;
   assign step_negative_external_seven_o = state_q.neg_ext;

endmodule // aasc_step_cfg
`default_nettype wire

// ==== rtl/aasc_pkg.sv ====
// Constants and types for the channel-B sequencer step configuration registers
package aasc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] AASC_IDX_STEP12 = 8'hDC;
   localparam logic [7:0] AASC_IDX_STEP13 = 8'hDD;
   localparam int AASC_IDX_LSB = 2;
   localparam int AASC_IDX_W = 8;
   localparam int AASC_STEPS = 2;

   // Reset values
   localparam logic [15:0] AASC_RST_STEP12 = 16'h000C;
   localparam logic [15:0] AASC_RST_STEP13 = 16'h000D;

   // Field layout
   localparam int AASC_EN_BIT = 15;
   localparam int AASC_GAIN_HI = 14;
   localparam int AASC_GAIN_LO = 13;
   localparam int AASC_NEG_BIT = 4;
   localparam int AASC_POS_HI = 3;
   localparam int AASC_POS_LO = 0;
   localparam logic [15:0] AASC_WR_MASK = 16'hE01F;

   // Gain codes and resulting factors
   localparam logic [1:0] AASC_GAIN_CODE_X1 = 2'h0;
   localparam logic [1:0] AASC_GAIN_CODE_X2 = 2'h1;
   localparam logic [2:0] AASC_GAIN_X1 = 3'h1;
   localparam logic [2:0] AASC_GAIN_X2 = 3'h2;
   localparam logic [2:0] AASC_GAIN_X4 = 3'h4;

   // Positive-input codes
   localparam logic [3:0] AASC_POS_EXT_LAST = 4'h7;
   localparam logic [3:0] AASC_POS_TEMP = 4'h8;
   localparam logic [3:0] AASC_POS_SHORT = 4'h9;
   localparam logic [3:0] AASC_POS_DAC = 4'hA;
   localparam logic [3:0] AASC_POS_IO_DIV4 = 4'hC;
   localparam logic [3:0] AASC_POS_CORE_DIV2 = 4'hD;
   localparam logic [3:0] AASC_POS_ANA_PWR_DIV = 4'hE;
   localparam logic [3:0] AASC_POS_DIG_PWR_DIV = 4'hF;

   // Class of the selected positive source, one-hot, all zero for none
   typedef enum logic [5:0] {
      AASC_SRC_NONE = 6'h00,
      AASC_SRC_EXT = 6'h01,
      AASC_SRC_TEMP = 6'h02,
      AASC_SRC_SHORT = 6'h04,
      AASC_SRC_DAC = 6'h08,
      AASC_SRC_SUPPLY = 6'h10,
      AASC_SRC_RSVD = 6'h20
   } aasc_src_t;

endpackage

// ==== dv/aasc_step_cfg_sva.sv ====
// Assertions for the step configuration register block
`timescale 1ns/1ps
`default_nettype none
module aasc_step_cfg_sva
   import aasc_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [AASC_STEPS-1:0] step_active_o,
   input wire logic [AASC_STEPS-1:0][2:0] step_gain_factor_o,
   input wire logic [AASC_STEPS-1:0][3:0] step_positive_input_o,
   input wire logic [AASC_STEPS-1:0][5:0] step_source_class_o,
   input wire logic [AASC_STEPS-1:0] step_negative_auto_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   a_rsvd_zero: assert property (wb_dat_o[12:5] == 8'h00) else $error("rsvd set");
   a_off_quiet: assert property (!step_active_o[0] |-> step_gain_factor_o[0] == 3'h0
      && step_source_class_o[0] == 6'h00) else $error("off step drives");
   a_gain_legal: assert property (step_active_o[0] |->
      step_gain_factor_o[0] inside {3'h1, 3'h2, 3'h4}) else $error("bad gain");
   a_neg_auto: assert property (step_active_o[0] |->
      step_negative_auto_o[0] == step_positive_input_o[0][3]) else $error("bad auto");
   a_ext_class: assert property (step_active_o[0] && !step_positive_input_o[0][3] |->
      step_source_class_o[0] == AASC_SRC_EXT) else $error("bad ext");
   a_supply_cls: assert property (step_active_o[1] && step_positive_input_o[1][3:2] == 2'h3
      |-> step_source_class_o[1] == AASC_SRC_SUPPLY) else $error("bad supply");
   a_en_at_ack: assert property ($changed(step_active_o) |-> $rose(wb_ack_o))
      else $error("enable moved");
   c_write: cover property (wb_ack_o && step_active_o[0]);
   c_auto: cover property (step_negative_auto_o[0]);
   c_supply: cover property (step_source_class_o[1] == AASC_SRC_SUPPLY);
endmodule // aasc_step_cfg_sva
bind aasc_step_cfg aasc_step_cfg_sva chk_u (.*);
`default_nettype wire

// ==== dv/aasc_step_cfg_tb.sv ====
// Self-checking bench for the step configuration registers
`timescale 1ns/1ps
`default_nettype none
module aasc_step_cfg_tb import aasc_pkg::*;;
   logic clk_i = 1'b0, reset_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [9:0] wb_adr_i = 10'h000;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
   logic wb_ack_o;
   logic [1:0] step_active_o, step_negative_auto_o, step_negative_external_seven_o;
   logic [1:0][2:0] step_gain_factor_o;
   logic [1:0][3:0] step_positive_input_o;
   logic [1:0][5:0] step_source_class_o;
   int miscompares = 0, total_checks = 0;
   aasc_step_cfg dut_u (.*);
   initial forever #2 clk_i = ~clk_i;
   task check(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   // Holds the request until ack is sampled
   task bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   function automatic logic [5:0] cls(int c);
      return c < 8 ? 6'h01 : c == 8 ? 6'h02 : c == 9 ? 6'h04 : c == 10 ? 6'h08 : c == 11 ? 6'h20 : 6'h10;
   endfunction
   task t_reset;
      bus(1'b0, 10'h370, 32'h0000_0000);
      check("step12", q, 32'h0000_000C);
      bus(1'b0, 10'h374, 32'h0000_0000);
      check("step13", q, 32'h0000_000D);
      check("enables", 32'(step_active_o), 32'h0000_0000);
      $display("reset test done");
   endtask
   task t_codes;
      for (int c = 0; c < 16; c++) begin
         bus(1'b1, 10'h370, {16'h0000, 1'b1, 2'(c % 4), 8'h00, 1'b1, 4'(c)});
         check("pos", 32'(step_positive_input_o[0]), 32'(c));
         check("auto", 32'(step_negative_auto_o[0]), 32'(c > 7));
         check("seven", 32'(step_negative_external_seven_o[0]), 32'(c < 8));
         check("class", 32'(step_source_class_o[0]), 32'(cls(c)));
         check("gain", 32'(step_gain_factor_o[0]), c % 4 == 0 ? 1 : c % 4 == 1 ? 2 : 4);
      end
      $display("code test done");
   endtask
   task t_rsvd;
      bus(1'b1, 10'h374, 32'hFFFF_FFFF);
      bus(1'b0, 10'h374, 32'h0000_0000);
      check("rsvd", q, 32'h0000_E01F);
      check("gain13", 32'(step_gain_factor_o[1]), 32'h0000_0004);
      bus(1'b1, 10'h378, 32'h0000_0000);
      bus(1'b0, 10'h378, 32'h0000_0000);
      check("unmapped", q, 32'h0000_0000);
      bus(1'b1, 10'h370, 32'h0000_601F);
      check("off", 32'({step_gain_factor_o[0], step_source_class_o[0]}), 32'h0000_0000);
      wb_sel_i <= 4'h1;
      bus(1'b1, 10'h370, 32'h0000_FFF5);
      wb_sel_i <= 4'hF;
      bus(1'b0, 10'h370, 32'h0000_0000);
      check("lane", q, 32'h0000_6015);
      $display("reserved test done");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset;
      t_codes;
      t_rsvd;
      end_of_test;
   end
   initial begin
      #20000;
      miscompares++;
      end_of_test;
   end
endmodule // aasc_step_cfg_tb
`default_nettype wire
